//--- verilog/sirq_pkg.sv
package sirq_pkg;

	localparam int SIRQ_LINES = 16;

	// register byte offsets, data sits in the low bits of a 16-bit word
	localparam logic [7:0] SIRQ_OFS_MODE  = 8'he0;
	localparam logic [7:0] SIRQ_OFS_TRIG  = 8'he2;
	localparam logic [7:0] SIRQ_OFS_LSTAT = 8'he4;
	localparam logic [7:0] SIRQ_OFS_EVST  = 8'he6;
	localparam logic [7:0] SIRQ_OFS_EVCLR = 8'he8;
	localparam logic [7:0] SIRQ_OFS_EVEN  = 8'hea;

	// mode control field positions
	localparam int SIRQ_MODE_DRIVE_BIT = 0;
	localparam int SIRQ_MODE_POLL_BIT  = 1;
	localparam int SIRQ_MODE_WIDTH_LSB = 2;
	localparam int SIRQ_MODE_BITS      = 4;

	// start width encodings
	localparam logic [1:0] SIRQ_WIDTH_4 = 2'h0;
	localparam logic [1:0] SIRQ_WIDTH_6 = 2'h1;
	localparam logic [1:0] SIRQ_WIDTH_8 = 2'h2;

	// frame lengths in clocks, last slot phase and last slot number
	localparam logic [3:0] SIRQ_START_CLK_4  = 4'h4;
	localparam logic [3:0] SIRQ_START_CLK_6  = 4'h6;
	localparam logic [3:0] SIRQ_START_CLK_8  = 4'h8;
	localparam logic [3:0] SIRQ_STOP_CLK_CON = 4'h2;
	localparam logic [3:0] SIRQ_STOP_CLK_QT  = 4'h3;
	localparam logic [1:0] SIRQ_SLOT_LAST_PH = 2'h2;
	localparam logic [3:0] SIRQ_SLOT_LAST    = 4'hf;

	// values after reset
	localparam logic [3:0]  SIRQ_MODE_RST  = 4'h0;
	localparam logic [15:0] SIRQ_TRIG_RST  = 16'h0000;
	localparam logic [15:0] SIRQ_LSTAT_RST = 16'h0000;
	localparam logic [15:0] SIRQ_EVST_RST  = 16'h0000;
	localparam logic [15:0] SIRQ_EVEN_RST  = 16'h0000;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_START,
		ST_START_REC,
		ST_START_TA,
		ST_SLOT,
		ST_STOP,
		ST_STOP_REC,
		ST_STOP_TA,
		ST_QUIET_WAIT
	} sirq_state_e;

endpackage : sirq_pkg

//--- verilog/sirq_slot.sv
`timescale 1ns/1ps
module sirq_slot
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic sample_i,
	input  wire logic asserted_i,
	input  wire logic level_mode_i,
	input  wire logic clear_i,
	output logic      level_o,
	output logic      edge_o
);
	import sirq_pkg::*;

	typedef struct packed {
		logic level;
		logic prev;
		logic edge_p;
	} sirq_slot_s;

	sirq_slot_s r;
	sirq_slot_s next_r;

	always_comb
	begin
		next_r = r;
		next_r.edge_p = 1'b0;
		if (sample_i)
		begin
			next_r.prev = asserted_i;
			// edge lines only pulse, never touch level status
			next_r.edge_p = asserted_i & ~r.prev & ~level_mode_i;
		end
		// set beats the write-one clear in the same cycle
		next_r.level = (r.level & ~clear_i) |
			(sample_i & asserted_i & level_mode_i);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign level_o = r.level;
	assign edge_o  = r.edge_p;

endmodule : sirq_slot

//--- verilog/sirq_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - start pulse 4, 6 or 8 clocks
// - poll bit: clear continuous, set quiet
// - recovery: drive high, or float if set
// - per-line edge or level select bit
// - level line signalled sets status bit
// - write one clears and re-arms status
// - edge lines never set level status
// - three resets restore all defaults
// - mode bits 7:4 read zero
// - status bit index equals interrupt number
module sirq_ctrl
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        link_reset_input_n_i,
	input  wire logic        global_reset_input_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        serirq_i,
	output logic             serirq_o,
	output logic             serirq_oe_o,
	output logic      [15:0] line_edge_o,
	output logic             irq_o
);
	import sirq_pkg::*;

	typedef struct packed {
		sirq_state_e state;
		logic [3:0]  cnt;
		logic [1:0]  phase;
		logic [3:0]  slot;
		logic        quiet_frame;
		logic [3:0]  mode;
		logic [15:0] line_trigger_select;
		logic [15:0] ev_status;
		logic [15:0] ev_enable;
		logic [15:0] rdata;
		logic        pin_o;
		logic        pin_oe;
	} sirq_ctrl_s;

	sirq_ctrl_s  r;
	sirq_ctrl_s  next_r;
	logic        rst_all_n;
	logic        sample;
	logic [15:0] sample_vec;
	logic [15:0] clr_lvl;
	logic [15:0] clr_ev;
	logic [15:0] line_asserted_flag;
	logic [15:0] edge_vec;
	logic        continuous_quiet_select;
	logic        recovery_drive_select;
	logic [1:0]  start_width;

	// any of the three resets returns everything to defaults
	assign rst_all_n = rst_n_i & link_reset_input_n_i &
		global_reset_input_n_i;

	assign recovery_drive_select   = r.mode[SIRQ_MODE_DRIVE_BIT];
	assign continuous_quiet_select = r.mode[SIRQ_MODE_POLL_BIT];
	assign start_width = r.mode[SIRQ_MODE_WIDTH_LSB +: 2];

	function automatic logic [3:0] start_len(input logic [1:0] w);
		begin
			unique case (w)
				SIRQ_WIDTH_6:
					start_len = SIRQ_START_CLK_6;
				SIRQ_WIDTH_8:
					start_len = SIRQ_START_CLK_8;
				// reserved code keeps the frame well formed
				default:
					start_len = SIRQ_START_CLK_4;
			endcase
		end
	endfunction : start_len

	always_comb
	begin
		next_r = r;
		sample = 1'b0;
		clr_lvl = 16'h0000;
		clr_ev = 16'h0000;
		next_r.rdata = 16'h0000;

		if (wr_i)
		begin
			case (addr_i)
				SIRQ_OFS_MODE:
					next_r.mode = wdata_i[SIRQ_MODE_BITS-1:0];
				SIRQ_OFS_TRIG:
					next_r.line_trigger_select = wdata_i;
				SIRQ_OFS_LSTAT:
					clr_lvl = wdata_i;
				SIRQ_OFS_EVCLR:
					clr_ev = wdata_i;
				SIRQ_OFS_EVEN:
					next_r.ev_enable = wdata_i;
				default:
					;
			endcase
		end

		// read data stands only in the cycle after the strobe
		if (rd_i)
		begin
			case (addr_i)
				SIRQ_OFS_MODE:
					next_r.rdata = {12'h000, r.mode};
				SIRQ_OFS_TRIG:
					next_r.rdata = r.line_trigger_select;
				SIRQ_OFS_LSTAT:
					next_r.rdata = line_asserted_flag;
				SIRQ_OFS_EVST:
					next_r.rdata = r.ev_status;
				SIRQ_OFS_EVEN:
					next_r.rdata = r.ev_enable;
				default:
					next_r.rdata = 16'h0000;
			endcase
		end

		// edge event set wins over a clear in the same cycle
		next_r.ev_status = (r.ev_status & ~clr_ev) | edge_vec;

		unique case (r.state)
			ST_IDLE:
			begin
				next_r.state = ST_START;
				next_r.cnt = start_len(start_width) - 4'h1;
			end
			ST_START:
			begin
				if (r.cnt == 4'h0)
					next_r.state = ST_START_REC;
				else
					next_r.cnt = r.cnt - 4'h1;
			end
			ST_START_REC:
				next_r.state = ST_START_TA;
			ST_START_TA:
			begin
				next_r.state = ST_SLOT;
				next_r.phase = 2'h0;
				next_r.slot = 4'h0;
			end
			ST_SLOT:
			begin
				// peripheral pulls low in the first clock of its slot
				if (r.phase == 2'h0)
					sample = 1'b1;
				if (r.phase == SIRQ_SLOT_LAST_PH)
				begin
					next_r.phase = 2'h0;
					if (r.slot == SIRQ_SLOT_LAST)
					begin
						next_r.state = ST_STOP;
						// stop length tells peripherals the next mode
						next_r.quiet_frame = continuous_quiet_select;
						if (continuous_quiet_select)
							next_r.cnt = SIRQ_STOP_CLK_QT - 4'h1;
						else
							next_r.cnt = SIRQ_STOP_CLK_CON - 4'h1;
					end
					else
						next_r.slot = r.slot + 4'h1;
				end
				else
					next_r.phase = r.phase + 2'h1;
			end
			ST_STOP:
			begin
				if (r.cnt == 4'h0)
					next_r.state = ST_STOP_REC;
				else
					next_r.cnt = r.cnt - 4'h1;
			end
			ST_STOP_REC:
				next_r.state = ST_STOP_TA;
			ST_STOP_TA:
			begin
				if (r.quiet_frame)
					next_r.state = ST_QUIET_WAIT;
				else
					next_r.state = ST_IDLE;
			end
			ST_QUIET_WAIT:
			begin
				// peripheral gave the first start clock already
				if (!serirq_i)
				begin
					next_r.state = ST_START;
					next_r.cnt = start_len(start_width) - 4'h2;
				end
				else if (!continuous_quiet_select)
					next_r.state = ST_IDLE;
			end
		endcase

		// pin follows the state it will be in, so both flops align
		next_r.pin_o = 1'b1;
		next_r.pin_oe = 1'b0;
		unique case (next_r.state)
			ST_START,
			ST_STOP:
			begin
				next_r.pin_o = 1'b0;
				next_r.pin_oe = 1'b1;
			end
			ST_START_REC,
			ST_STOP_REC:
				next_r.pin_oe = ~recovery_drive_select;
			default:
				next_r.pin_oe = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_all_n)
		begin
			r <= '0;
			r.state <= ST_IDLE;
			r.mode <= SIRQ_MODE_RST;
			r.line_trigger_select <= SIRQ_TRIG_RST;
			r.ev_status <= SIRQ_EVST_RST;
			r.ev_enable <= SIRQ_EVEN_RST;
			r.pin_o <= 1'b1;
		end
		else
			r <= next_r;
	end

	genvar gi;
	generate
		for (gi = 0; gi < SIRQ_LINES; gi++)
		begin : g_line
			// slot number gi maps onto status bit gi
			assign sample_vec[gi] = sample &&
				(r.slot == 4'(gi));
			sirq_slot u_slot
			(
				.clk_i        (clk_i),
				.rst_n_i      (rst_all_n),
				.sample_i     (sample_vec[gi]),
				.asserted_i   (~serirq_i),
				.level_mode_i (r.line_trigger_select[gi]),
				.clear_i      (clr_lvl[gi]),
				.level_o      (line_asserted_flag[gi]),
				.edge_o       (edge_vec[gi])
			);
		end
	endgenerate

	assign rdata_o     = r.rdata;
	assign serirq_o    = r.pin_o;
	assign serirq_oe_o = r.pin_oe;
	assign line_edge_o = edge_vec;
	// level status needs no separate sticky bit, it already holds
	assign irq_o = |((r.ev_status | line_asserted_flag) & r.ev_enable);

endmodule : sirq_ctrl

//--- tb/sirq_peer.sv
`timescale 1ns/1ps
module sirq_peer
(
	input  wire logic        clk_i,
	input  wire logic        line_i,
	input  wire logic [15:0] mask_i,
	output logic             oe_o
);
	logic [3:0] low = 4'h0;
	logic [7:0] cnt = 8'hff;
	initial oe_o = 1'b0;
	// a low run of four or more is a start; a stop is shorter
	always @(posedge clk_i)
	begin
		low <= line_i ? 4'h0 : low + 4'(low != 4'hf);
		if (line_i && low >= 4'h4)
			cnt <= 8'h0;
		else if (cnt != 8'hff)
			cnt <= cnt + 8'h1;
		oe_o <= cnt % 3 == 0 && cnt < 48 && mask_i[cnt / 3];
	end
endmodule : sirq_peer

//--- tb/sirq_ctrl_chk.sv
`timescale 1ns/1ps
module sirq_ctrl_chk
	import sirq_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        link_reset_input_n_i,
	input wire logic        global_reset_input_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        serirq_i,
	input wire logic        serirq_o,
	input wire logic        serirq_oe_o,
	input wire logic [15:0] line_edge_o,
	input wire logic        irq_o
);
	logic       ok;
	logic       lo;
	logic       drv;
	logic [3:0] run;
	assign ok = rst_n_i & link_reset_input_n_i & global_reset_input_n_i;
	assign lo = serirq_oe_o & !serirq_o;
	// shadow of the drive bit, taken from bus writes
	always_ff @(posedge clk_i)
	begin
		if (!ok)
			drv <= 1'b0;
		else if (wr_i && addr_i == SIRQ_OFS_MODE)
			drv <= wdata_i[SIRQ_MODE_DRIVE_BIT];
		run <= lo ? run + 4'h1 : 4'h0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!ok);
	// a reset that cuts a low run is no frame end
	sequence s_end_low;
		$fell(lo) && $past(ok);
	endsequence
	a_run_len: assert property (
		s_end_low |-> run inside {2, 3, 4, 6, 8})
		else $error("bad low run length");
	// recovery drive was chosen a cycle before it shows
	a_rec_drive: assert property (
		s_end_low |-> serirq_oe_o == !$past(drv) && serirq_o)
		else $error("bad recovery drive");
	a_ta_float: assert property (s_end_low |=> !serirq_oe_o [*2])
		else $error("line driven in turnaround");
	a_rd_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
		else $error("read data outside answer cycle");
	a_mode_rsvd: assert property (
		rd_i && addr_i == SIRQ_OFS_MODE |=> rdata_o[15:4] == 12'h0)
		else $error("mode upper bits not zero");
	a_edge_wire: assert property (
		|line_edge_o |-> !$past(serirq_i) && !$past(serirq_oe_o))
		else $error("edge without low slot");
	a_edge_pulse: assert property (|line_edge_o |=> line_edge_o == 16'h0)
		else $error("edge pulse too long");
	a_irq_clear: assert property (
		$fell(irq_o) && $past(ok) |-> $past(wr_i))
		else $error("irq fell without write");
	a_reset_out: assert property (
		disable iff (1'b0) !ok |=>
		!irq_o && !serirq_oe_o && line_edge_o == 16'h0)
		else $error("outputs not cleared by reset");
endmodule : sirq_ctrl_chk
bind sirq_ctrl sirq_ctrl_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.link_reset_input_n_i(link_reset_input_n_i), .addr_i(addr_i),
	.global_reset_input_n_i(global_reset_input_n_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serirq_i(serirq_i),
	.serirq_o(serirq_o), .serirq_oe_o(serirq_oe_o),
	.line_edge_o(line_edge_o), .irq_o(irq_o));

//--- tb/sirq_ctrl_test.sv
`timescale 1ns/1ps
module sirq_ctrl_test;
	import sirq_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [1:0]  rsts_n = 2'h3;
	logic [7:0]  addr = 8'h0;
	logic [15:0] wdata = 16'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] mask = 16'h0;
	logic [15:0] rdata, edges, n;
	logic        so, oe, poe, irq, line;
	logic        pull = 1'b0;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	assign line = !((oe & !so) | poe | pull);
	always #20 clk_i = !clk_i;
	sirq_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.link_reset_input_n_i(rsts_n[0]), .global_reset_input_n_i(rsts_n[1]),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.serirq_i(line), .serirq_o(so), .serirq_oe_o(oe),
		.line_edge_o(edges), .irq_o(irq));
	sirq_peer u_peer (.clk_i(clk_i), .line_i(line), .mask_i(mask), .oe_o(poe));
	task automatic end_sim();
		$display("checks %0d fails %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_chk
	// longest of three low runs, so a start is always among them
	task automatic widest(output logic [15:0] w);
		w = 16'h0;
		repeat (3)
		begin
			n = 16'h0;
			@(negedge clk_i);
			while (line) @(negedge clk_i);
			while (!line)
			begin
				n++;
				@(negedge clk_i);
			end
			if (n > w) w = n;
		end
	endtask : widest
	task automatic t_regs();
		logic [7:0] ofs [5] = '{8'he0, 8'he2, 8'he4, 8'he6, 8'hea};
		foreach (ofs[i]) rd_chk(ofs[i], 16'h0);
		wr_reg(SIRQ_OFS_MODE, 16'h00ff);
		rd_chk(SIRQ_OFS_MODE, 16'h000f);
		rd_chk(8'hf0, 16'h0);
		wr_reg(SIRQ_OFS_MODE, 16'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_width();
		logic [15:0] wid [4] = '{16'h4, 16'h6, 16'h8, 16'h4};
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(SIRQ_OFS_MODE, 16'(c) << 2);
			repeat (70) @(posedge clk_i);
			widest(n);
			chk(n, wid[c]);
		end
		wr_reg(SIRQ_OFS_MODE, 16'h0);
		$display("t_width done");
	endtask : t_width
	task automatic t_lines();
		wr_reg(SIRQ_OFS_TRIG, 16'h0008);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk_i) mask <= 16'h0028;
			n = 16'h0;
			// only the edge line pulses, and only once
			repeat (150) @(negedge clk_i) n += edges;
			chk(n, 16'h0020);
			@(posedge clk_i) mask <= 16'h0;
			rd_chk(SIRQ_OFS_LSTAT, 16'h0008);
			rd_chk(SIRQ_OFS_EVST, 16'h0020);
			wr_reg(SIRQ_OFS_EVEN, 16'h0008);
			chk(16'(irq), 16'h1);
			repeat (150) @(posedge clk_i);
			wr_reg(SIRQ_OFS_LSTAT, 16'h0008);
			chk(16'(irq), 16'h0);
			rd_chk(SIRQ_OFS_LSTAT, 16'h0);
			wr_reg(SIRQ_OFS_EVEN, 16'h0020);
			chk(16'(irq), 16'h1);
			wr_reg(SIRQ_OFS_EVEN, 16'h0);
			chk(16'(irq), 16'h0);
			wr_reg(SIRQ_OFS_EVCLR, 16'h0020);
			rd_chk(SIRQ_OFS_EVST, 16'h0);
		end
		$display("t_lines done");
	endtask : t_lines
	task automatic t_modes();
		wr_reg(SIRQ_OFS_MODE, 16'h0001);
		repeat (130) @(posedge clk_i);
		wr_reg(SIRQ_OFS_MODE, 16'h0002);
		repeat (80) @(posedge clk_i);
		n = 16'h0;
		// quiet: no frame starts until someone pulls the line low
		repeat (150) @(negedge clk_i) n += 16'(!line);
		chk(n, 16'h0);
		// a peripheral opens a quiet frame with one low clock
		@(posedge clk_i) pull <= 1'b1;
		@(posedge clk_i) pull <= 1'b0;
		n = 16'h0;
		repeat (10) @(negedge clk_i) n += 16'(!line);
		chk(n, 16'h3);
		wr_reg(SIRQ_OFS_MODE, 16'h0);
		widest(n);
		chk(n, 16'h4);
		$display("t_modes done");
	endtask : t_modes
	task automatic t_rsts();
		for (int k = 0; k < 2; k++)
		begin
			wr_reg(SIRQ_OFS_TRIG, 16'hffff);
			wr_reg(SIRQ_OFS_MODE, 16'h000d);
			@(posedge clk_i) rsts_n[k] <= 1'b0;
			@(posedge clk_i) rsts_n[k] <= 1'b1;
			rd_chk(SIRQ_OFS_TRIG, 16'h0);
			rd_chk(SIRQ_OFS_MODE, 16'h0);
		end
		$display("t_rsts done");
	endtask : t_rsts
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			fail_count++;
			end_sim();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_width();
		t_lines();
		t_modes();
		t_rsts();
		end_sim();
	end
endmodule : sirq_ctrl_test
